// *** hdl/srza_top.sv ***
// Contract
// RULE1 - while clearing, only the clear engine reaches the ram; others denied
// RULE2 - while ciphering, only the key encryption unit reaches the ram
// RULE3 - host ram reads and writes only while the ram controller is idle
// RULE4 - host accesses are dropped whenever zeroize done is low
// RULE5 - zeroize done is the reset of encryption unit and controller
// RULE6 - zeroize pin or zeroize bit clears plaintext and ciphertext memory
// RULE7 - zeroize clears start, length, control, error, iv registers and engine
// RULE8 - a detected intrusion starts zeroization by itself
// RULE9 - secure state selects chip key, otherwise the fixed default key
// RULE10 - the key goes only to the encryption unit, never to a bus
// RULE11 - plaintext and ciphertext live in one 2 kbyte on-chip ram
// RULE12 - 32-bit programmable secure timer times the move to secure
// RULE13 - an expired secure timer raises an error to the security monitor
// RULE14 - active jtag or scan alerts the secure state controller
// RULE15 - a readable status register shows which debug signals are active
// RULE16 - policy joins security state and ram requests to permit accesses
// RULE17 - control and status registers answer supervisor accesses only
// RULE18 - finished zeroize raises done and returns the ram to idle
//
// The register addresses and the strobed register port are this design's own decisions.
module srza_top (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_supv,
	output logic [31:0] reg_rdata,
	// host ram port
	input wire logic host_req,
	input wire logic host_we,
	input wire logic [8:0] host_addr,
	input wire logic [31:0] host_wdata,
	output logic [31:0] host_rdata,
	output logic host_ack,
	output logic host_deny,
	// key encryption unit port
	input wire logic kem_req,
	input wire logic kem_we,
	input wire logic [8:0] kem_addr,
	input wire logic [31:0] kem_wdata,
	input wire logic kem_done,
	output logic [31:0] kem_rdata,
	output logic kem_grant,
	output logic kem_start,
	output logic kem_decrypt,
	output logic kem_rst_n,
	output logic [8:0] kem_red_start,
	output logic [8:0] kem_black_start,
	output logic [8:0] kem_length,
	output logic [31:0] kem_iv0,
	output logic [31:0] kem_iv1,
	output logic [127:0] kem_key,
	// key source
	input wire logic [127:0] chip_key,
	// pins
	input wire logic zeroize_pin,
	input wire logic intrusion_pin,
	input wire logic jtag_active,
	input wire logic scan_active,
	// security monitor
	output logic security_monitor_err,
	output logic ssc_debug_alert,
	output logic secure_state,
	output logic zeroize_done,
	output logic irq
);

	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic [3:0] pin_s3_q;
	logic [3:0] pins_in;
	logic [3:0] pin_rise;
	logic zpin_rise;
	logic intr_rise;
	logic debug_on;
	logic debug_rise;

	srza_pkg::srza_ram_e ram_q;
	srza_pkg::srza_ram_e ram_d;
	srza_pkg::srza_ssc_e ssc_q;
	srza_pkg::srza_ssc_e ssc_d;
	logic [8:0] zaddr_q;
	logic [8:0] zaddr_d;
	logic zdone_q;
	logic zdone_d;

	logic [31:0] mem [srza_pkg::SRAM_WORDS];
	logic mem_we;
	logic [8:0] mem_addr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_rword;

	logic in_idle;
	logic in_zero;
	logic own_kem;
	logic policy_ok;
	logic host_ok;
	logic host_go;
	logic kem_rd;
	logic zero_last;

	logic wr_ok;
	logic rd_ok;
	logic sel_red;
	logic sel_black;
	logic sel_len;
	logic sel_ctrl;
	logic sel_err;
	logic sel_iv0;
	logic sel_iv1;
	logic sel_ictl;
	logic sel_ists;
	logic sel_imask;
	logic sel_tload;
	logic sel_tcount;
	logic sel_dbg;
	logic sel_stat;
	logic sel_ssc;
	logic [31:0] rd_mux;
	logic [31:0] stat_word;

	logic zero_req;
	logic zero_start;
	logic cipher_go;
	logic ssc_go;
	logic tmr_load;
	logic tmr_exp;
	logic ists_clr;

	logic [8:0] red_q;
	logic [8:0] black_q;
	logic [8:0] len_q;
	logic decrypt_q;
	logic [31:0] iv0_q;
	logic [31:0] iv1_q;
	logic [2:0] err_q;
	logic [2:0] err_d;
	logic [2:0] err_ev;
	logic [5:0] ists_q;
	logic [5:0] ists_d;
	logic [5:0] ev;
	logic [5:0] imask_q;
	logic [31:0] tmr_q;
	logic tmr_run_q;
	logic [127:0] key_q;
	logic kem_start_q;
	logic host_ack_q;
	logic host_deny_q;
	logic [31:0] host_rdata_q;
	logic [31:0] kem_rdata_q;
	logic [31:0] reg_rdata_q;

	// pin synchronisers and edge detect
	assign pins_in = {scan_active, jtag_active, intrusion_pin, zeroize_pin};
	assign pin_rise = pin_s2_q & ~pin_s3_q;
	assign zpin_rise = pin_rise[0];
	assign intr_rise = pin_rise[1];
	assign debug_on = |pin_s2_q[3:2];
	assign debug_rise = |pin_rise[3:2];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			pin_s3_q <= 4'h0;
		end else if (clk_en) begin
			pin_s1_q <= pins_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// register decode, supervisor only
	assign wr_ok = reg_wr & reg_supv; // see RULE17
	assign rd_ok = reg_rd & reg_supv; // see RULE17
	assign sel_red = reg_addr == srza_pkg::OFF_RED;
	assign sel_black = reg_addr == srza_pkg::OFF_BLACK;
	assign sel_len = reg_addr == srza_pkg::OFF_LEN;
	assign sel_ctrl = reg_addr == srza_pkg::OFF_CTRL;
	assign sel_err = reg_addr == srza_pkg::OFF_ERR;
	assign sel_iv0 = reg_addr == srza_pkg::OFF_IV0;
	assign sel_iv1 = reg_addr == srza_pkg::OFF_IV1;
	assign sel_ictl = reg_addr == srza_pkg::OFF_ICTL;
	assign sel_ists = reg_addr == srza_pkg::OFF_ISTS;
	assign sel_imask = reg_addr == srza_pkg::OFF_IMASK;
	assign sel_tload = reg_addr == srza_pkg::OFF_TLOAD;
	assign sel_tcount = reg_addr == srza_pkg::OFF_TCOUNT;
	assign sel_dbg = reg_addr == srza_pkg::OFF_DBG;
	assign sel_stat = reg_addr == srza_pkg::OFF_STAT;
	assign sel_ssc = reg_addr == srza_pkg::OFF_SSC;

	// ram ownership and policy
	assign in_idle = ram_q == srza_pkg::RAM_IDLE;
	assign in_zero = ram_q == srza_pkg::RAM_ZERO;
	assign own_kem = (ram_q == srza_pkg::RAM_KEM) & zdone_q; // see RULE2
	assign policy_ok = ssc_q != srza_pkg::SSC_INIT; // see RULE16
	assign host_ok = in_idle & zdone_q & policy_ok; // see RULE3 see RULE4
	assign host_go = host_req & host_ok;
	assign kem_rd = own_kem & kem_req & ~kem_we;
	assign zero_last = in_zero & (zaddr_q == srza_pkg::SRAM_LAST);

	// single ram, one owner at a time
	assign mem_we = in_zero | (own_kem & kem_req & kem_we) | // see RULE1
		(host_go & host_we);
	assign mem_addr = in_zero ? zaddr_q : (own_kem ? kem_addr : host_addr);
	assign mem_wdata = in_zero ? srza_pkg::RST_WORD : // see RULE6
		(own_kem ? kem_wdata : host_wdata);
	assign mem_rword = mem[mem_addr];

	always_ff @(posedge clk) begin
		if (clk_en && mem_we) begin
			mem[mem_addr] <= mem_wdata; // see RULE11
		end
	end

	// triggers
	assign zero_req = zpin_rise | intr_rise | // see RULE8
		(wr_ok & sel_ictl & reg_wdata[srza_pkg::ICTL_ZERO_BIT]); // see RULE6
	assign zero_start = zero_req & ~in_zero;
	assign cipher_go = wr_ok & sel_ctrl & reg_wdata[srza_pkg::CTRL_START_BIT] &
		in_idle & zdone_q & ~zero_req;
	assign ssc_go = wr_ok & sel_ssc & reg_wdata[srza_pkg::SSC_GO_BIT];
	assign tmr_load = wr_ok & sel_tload;
	assign tmr_exp = tmr_run_q & (tmr_q == 32'h0000_0001) & // see RULE13
		~tmr_load;

	// ram controller next state
	always_comb begin
		ram_d = ram_q;
		zaddr_d = zaddr_q;
		zdone_d = zdone_q;
		unique case (ram_q)
			srza_pkg::RAM_IDLE: begin
				if (cipher_go) begin
					ram_d = srza_pkg::RAM_KEM;
				end
			end
			srza_pkg::RAM_KEM: begin
				if (kem_done || !zdone_q) begin
					ram_d = srza_pkg::RAM_IDLE; // see RULE5
				end
			end
			srza_pkg::RAM_ZERO: begin
				zaddr_d = zaddr_q + 9'h001;
				if (zero_last) begin
					ram_d = srza_pkg::RAM_IDLE; // see RULE18
					zdone_d = 1'b1; // see RULE18
				end
			end
		endcase
		if (zero_start) begin
			ram_d = srza_pkg::RAM_ZERO;
			zaddr_d = 9'h000;
			zdone_d = 1'b0;
		end
	end

	// security state controller
	always_comb begin
		ssc_d = ssc_q;
		unique case (ssc_q)
			srza_pkg::SSC_INIT: begin
				if (tmr_exp || debug_on || intr_rise) begin
					ssc_d = srza_pkg::SSC_NSEC; // see RULE14
				end else if (ssc_go && tmr_run_q) begin
					ssc_d = srza_pkg::SSC_SEC; // see RULE12
				end
			end
			srza_pkg::SSC_SEC: begin
				if (debug_on || intr_rise) begin
					ssc_d = srza_pkg::SSC_NSEC; // see RULE14
				end
			end
			srza_pkg::SSC_NSEC: begin
				ssc_d = srza_pkg::SSC_NSEC;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ram_q <= srza_pkg::RAM_ZERO;
			zaddr_q <= 9'h000;
			zdone_q <= 1'b0;
			ssc_q <= srza_pkg::SSC_INIT;
		end else if (clk_en) begin
			ram_q <= ram_d;
			zaddr_q <= zaddr_d;
			zdone_q <= zdone_d;
			ssc_q <= ssc_d;
		end
	end

	// events, set wins over read clear
	assign ists_clr = rd_ok & sel_ists;
	assign ev[srza_pkg::EV_ZDONE] = zero_last;
	assign ev[srza_pkg::EV_KDONE] = own_kem & kem_done;
	assign ev[srza_pkg::EV_TMR] = tmr_exp;
	assign ev[srza_pkg::EV_DBG] = debug_rise;
	assign ev[srza_pkg::EV_DENY] = host_req & ~host_ok;
	assign ev[srza_pkg::EV_INTR] = intr_rise;

	for (genvar i = 0; i < srza_pkg::EV_W; i++) begin : g_ev
		assign ists_d[i] = ev[i] | (ists_q[i] & ~ists_clr);
	end

	assign err_ev[srza_pkg::ERR_TMR_BIT] = tmr_exp; // see RULE13
	assign err_ev[srza_pkg::ERR_DENY_BIT] = host_req & ~host_ok;
	assign err_ev[srza_pkg::ERR_SUPV_BIT] = (reg_wr | reg_rd) & ~reg_supv;
	assign err_d = err_ev | // see RULE7
		(err_q & {srza_pkg::ERR_W{~zero_start}});

	// cipher setup registers, cleared by zeroize
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			red_q <= 9'h000;
			black_q <= 9'h000;
			len_q <= 9'h000;
			decrypt_q <= 1'b0;
			iv0_q <= srza_pkg::RST_WORD;
			iv1_q <= srza_pkg::RST_WORD;
		end else if (clk_en) begin
			if (zero_start) begin
				red_q <= 9'h000; // see RULE7
				black_q <= 9'h000;
				len_q <= 9'h000;
				decrypt_q <= 1'b0;
				iv0_q <= srza_pkg::RST_WORD;
				iv1_q <= srza_pkg::RST_WORD;
			end else if (wr_ok) begin
				if (sel_red) red_q <= reg_wdata[8:0];
				if (sel_black) black_q <= reg_wdata[8:0];
				if (sel_len) len_q <= reg_wdata[8:0];
				if (sel_ctrl) decrypt_q <= reg_wdata[srza_pkg::CTRL_DECRYPT_BIT];
				if (sel_iv0) iv0_q <= reg_wdata;
				if (sel_iv1) iv1_q <= reg_wdata;
			end
		end
	end

	// status, mask and error registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err_q <= 3'h0;
			ists_q <= srza_pkg::RST_MASK;
			imask_q <= srza_pkg::RST_MASK;
		end else if (clk_en) begin
			err_q <= err_d;
			ists_q <= ists_d;
			if (wr_ok && sel_imask) begin
				imask_q <= reg_wdata[5:0];
			end
		end
	end

	// secure timer, counts down to expiry
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tmr_q <= srza_pkg::RST_WORD;
			tmr_run_q <= 1'b0;
		end else if (clk_en) begin
			if (tmr_load) begin
				tmr_q <= reg_wdata; // see RULE12
				tmr_run_q <= |reg_wdata;
			end else if (tmr_run_q) begin
				tmr_q <= tmr_q - 32'h0000_0001;
				if (tmr_exp) begin
					tmr_run_q <= 1'b0;
				end
			end
		end
	end

	// key select, held away from the register read path
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			key_q <= srza_pkg::DEFAULT_KEY;
		end else if (clk_en) begin
			key_q <= (ssc_q == srza_pkg::SSC_SEC) ? chip_key : // see RULE9
				srza_pkg::DEFAULT_KEY;
		end
	end

	// ram answers to host and encryption unit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_ack_q <= 1'b0;
			host_deny_q <= 1'b0;
			host_rdata_q <= srza_pkg::RST_WORD;
			kem_rdata_q <= srza_pkg::RST_WORD;
			kem_start_q <= 1'b0;
		end else if (clk_en) begin
			host_ack_q <= host_go;
			host_deny_q <= host_req & ~host_ok; // see RULE1 see RULE4
			kem_start_q <= cipher_go;
			if (zero_start) begin
				host_rdata_q <= srza_pkg::RST_WORD;
				kem_rdata_q <= srza_pkg::RST_WORD;
			end else begin
				if (host_go && !host_we) host_rdata_q <= mem_rword;
				if (kem_rd) kem_rdata_q <= mem_rword;
			end
		end
	end

	// register read mux
	assign stat_word = {23'h0, ssc_q, ram_q, tmr_run_q, zdone_q, debug_on};
	assign rd_mux = ({32{sel_red}} & 32'(red_q)) |
		({32{sel_black}} & 32'(black_q)) |
		({32{sel_len}} & 32'(len_q)) |
		({32{sel_ctrl}} & {30'h0, decrypt_q, own_kem}) |
		({32{sel_err}} & 32'(err_q)) |
		({32{sel_iv0}} & iv0_q) |
		({32{sel_iv1}} & iv1_q) |
		({32{sel_ists}} & 32'(ists_q)) |
		({32{sel_imask}} & 32'(imask_q)) |
		({32{sel_tcount}} & tmr_q) |
		({32{sel_dbg}} & {30'h0, pin_s2_q[3:2]}) | // see RULE15
		({32{sel_stat}} & stat_word);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q <= srza_pkg::RST_WORD;
		end else if (clk_en) begin
			reg_rdata_q <= rd_ok ? rd_mux : srza_pkg::RST_WORD; // see RULE17
		end
	end

	// outputs
	assign reg_rdata = reg_rdata_q;
	assign host_rdata = host_rdata_q;
	assign host_ack = host_ack_q;
	assign host_deny = host_deny_q;
	assign kem_rdata = kem_rdata_q;
	assign kem_grant = own_kem; // see RULE2
	assign kem_start = kem_start_q;
	assign kem_decrypt = decrypt_q;
	assign kem_rst_n = zdone_q; // see RULE5
	assign kem_red_start = red_q;
	assign kem_black_start = black_q;
	assign kem_length = len_q;
	assign kem_iv0 = iv0_q;
	assign kem_iv1 = iv1_q;
	assign kem_key = key_q; // see RULE10
	assign security_monitor_err = err_q[srza_pkg::ERR_TMR_BIT]; // see RULE13
	assign ssc_debug_alert = debug_on; // see RULE14
	assign secure_state = ssc_q == srza_pkg::SSC_SEC;
	assign zeroize_done = zdone_q;
	assign irq = |(ists_q & imask_q);

endmodule : srza_top

// *** hdl/srza_pkg.sv ***
package srza_pkg;

	// secure ram geometry: 2 kbytes of 32-bit words
	localparam int unsigned SRAM_WORDS = 512;
	localparam int unsigned SRAM_AW = 9;
	localparam logic [8:0] SRAM_LAST = 9'h1ff;

	// key width and the fixed key of the non-secure state
	localparam int unsigned KEY_W = 128;
	localparam logic [127:0] DEFAULT_KEY =
		128'h5a5a_0f0f_a5a5_f0f0_3c3c_c3c3_6969_9696;

	// register offsets
	localparam logic [7:0] OFF_RED = 8'h00;
	localparam logic [7:0] OFF_BLACK = 8'h04;
	localparam logic [7:0] OFF_LEN = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0c;
	localparam logic [7:0] OFF_ERR = 8'h10;
	localparam logic [7:0] OFF_IV0 = 8'h14;
	localparam logic [7:0] OFF_IV1 = 8'h18;
	localparam logic [7:0] OFF_ICTL = 8'h1c;
	localparam logic [7:0] OFF_ISTS = 8'h20;
	localparam logic [7:0] OFF_IMASK = 8'h24;
	localparam logic [7:0] OFF_TLOAD = 8'h28;
	localparam logic [7:0] OFF_TCOUNT = 8'h2c;
	localparam logic [7:0] OFF_DBG = 8'h30;
	localparam logic [7:0] OFF_STAT = 8'h34;
	localparam logic [7:0] OFF_SSC = 8'h38;

	// field positions
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned CTRL_DECRYPT_BIT = 1;
	localparam int unsigned ICTL_ZERO_BIT = 0;
	localparam int unsigned SSC_GO_BIT = 0;
	localparam int unsigned ERR_TMR_BIT = 0;
	localparam int unsigned ERR_DENY_BIT = 1;
	localparam int unsigned ERR_SUPV_BIT = 2;
	localparam int unsigned ERR_W = 3;
	localparam int unsigned EV_ZDONE = 0;
	localparam int unsigned EV_KDONE = 1;
	localparam int unsigned EV_TMR = 2;
	localparam int unsigned EV_DBG = 3;
	localparam int unsigned EV_DENY = 4;
	localparam int unsigned EV_INTR = 5;
	localparam int unsigned EV_W = 6;
	localparam int unsigned PIN_W = 4;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [5:0] RST_MASK = 6'h00;

	// secure ram owner states
	typedef enum logic [2:0] {
		RAM_IDLE = 3'h1,
		RAM_ZERO = 3'h2,
		RAM_KEM = 3'h4
	} srza_ram_e;

	// security states
	typedef enum logic [2:0] {
		SSC_INIT = 3'h1,
		SSC_SEC = 3'h2,
		SSC_NSEC = 3'h4
	} srza_ssc_e;

endpackage : srza_pkg

// *** tb/srza_chk.sv ***
module srza_chk (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_supv,
	input wire logic [31:0] reg_rdata,
	// host ram port
	input wire logic host_req,
	input wire logic host_ack,
	input wire logic host_deny,
	// encryption unit
	input wire logic kem_grant,
	input wire logic kem_rst_n,
	input wire logic [8:0] kem_red_start,
	input wire logic [8:0] kem_length,
	input wire logic [31:0] kem_iv0,
	input wire logic [127:0] kem_key,
	input wire logic [127:0] chip_key,
	// pins and monitor
	input wire logic intrusion_pin,
	input wire logic jtag_active,
	input wire logic ssc_debug_alert,
	input wire logic secure_state,
	input wire logic zeroize_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] zcnt_q;
	logic zwr;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	assign zwr = clk_en && reg_wr && reg_supv && reg_wdata[0]
		&& reg_addr == srza_pkg::OFF_ICTL;
	// cycles spent with zeroize done low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			zcnt_q <= 10'h000;
		end else if (clk_en) begin
			zcnt_q <= zeroize_done ? 10'h000 : zcnt_q + 10'h001;
		end
	end
	a_deny_undone: assert property (clk_en && host_req && !zeroize_done
		|=> host_deny && !host_ack) else $error("host access while not done");
	a_cipher_excl: assert property (clk_en && host_req && kem_grant
		|=> host_deny) else $error("host access during cipher");
	a_one_answer: assert property (clk_en && host_req
		|=> host_ack != host_deny) else $error("host answer not unique");
	a_rst_follow: assert property (kem_rst_n == zeroize_done
		&& (zeroize_done || !kem_grant))
		else $error("unit reset differs from done");
	a_zero_clear: assert property (zwr && zeroize_done |=> !zeroize_done
		&& kem_red_start == 9'h000 && kem_length == 9'h000
		&& kem_iv0 == 32'h0) else $error("zeroize did not clear");
	a_zero_length: assert property ($rose(zeroize_done)
		|-> zcnt_q == 10'h200) else $error("zeroize length wrong");
	a_intr_zero: assert property ($rose(intrusion_pin) && zeroize_done
		|-> ##[2:5] !zeroize_done) else $error("intrusion did not zeroize");
	a_key_sec: assert property (secure_state && $past(secure_state)
		&& $stable(chip_key) |-> kem_key == chip_key)
		else $error("secure key wrong");
	a_key_nsec: assert property (!secure_state && !$past(secure_state)
		|-> kem_key == srza_pkg::DEFAULT_KEY) else $error("default key wrong");
	a_supv_only: assert property (clk_en && reg_rd && !reg_supv
		|=> reg_rdata == 32'h0) else $error("user read returned data");
	a_dbg_alert: assert property ($rose(jtag_active)
		|-> ##[1:6] ssc_debug_alert) else $error("no debug alert");
endmodule : srza_chk

bind srza_top srza_chk i_chk (.*);

// *** tb/srza_kem_model.sv ***
module srza_kem_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// control from the block
	input wire logic kem_start,
	input wire logic kem_grant,
	input wire logic kem_rst_n,
	input wire logic [8:0] kem_red_start,
	input wire logic [7:0] lat,
	// ram side
	output logic kem_req,
	output logic kem_we,
	output logic [8:0] kem_addr,
	output logic [31:0] kem_wdata,
	output logic kem_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic busy_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst || !kem_rst_n) begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (kem_start) begin
			busy_q <= 1'b1;
			cnt_q <= lat;
		end else if (busy_q) begin
			busy_q <= cnt_q != 8'h00;
			cnt_q <= cnt_q - 8'h01;
		end
	end
	// one word read, then written, while the unit owns the ram
	assign kem_req = busy_q && kem_grant &&
		(cnt_q == 8'h02 || cnt_q == 8'h01);
	assign kem_we = cnt_q == 8'h01;
	assign kem_addr = kem_req ? kem_red_start : ~kem_red_start;
	assign kem_wdata = kem_req ? {24'hc0de00, lat} : ~{24'hc0de00, lat};
	assign kem_done = busy_q && cnt_q == 8'h00;
endmodule : srza_kem_model

// *** tb/srza_tb_top.sv ***
module srza_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, clk_en, reg_wr, reg_rd, reg_supv, host_req, host_we;
	logic kem_req, kem_we, kem_done, zeroize_pin, intrusion_pin, jtag_active;
	logic scan_active, host_ack, host_deny, kem_grant, kem_start, kem_decrypt;
	logic kem_rst_n, security_monitor_err, ssc_debug_alert, secure_state;
	logic zeroize_done, irq, rd_p;
	logic [7:0] reg_addr, lat;
	logic [8:0] host_addr, kem_addr, kem_red_start, kem_black_start, kem_length;
	logic [31:0] reg_wdata, reg_rdata, host_wdata, host_rdata, kem_wdata;
	logic [31:0] kem_rdata, kem_iv0, kem_iv1;
	logic [127:0] chip_key, kem_key;
	logic [33:0] hq[$];
	logic [31:0] rq[$];
	logic [31:0] rn;
	logic [33:0] hn;
	logic [8:0] aa[4];
	logic [31:0] dd[4];
	int err_count, comparisons, seed, i, j;
	srza_top i_srza_top (.*);
	srza_kem_model i_srza_kem_model (.*);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task end_of_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : rd
	// e: bit33 check data, bit32 ack expected, low word data
	task hx(input logic w, input logic [8:0] a, input logic [31:0] d,
		input logic [33:0] e);
		hq.push_back(e);
		host_req <= 1'b1;
		host_we <= w;
		host_addr <= a;
		host_wdata <= d;
		@(posedge clk);
		host_req <= 1'b0;
		@(posedge clk);
	endtask : hx
	task wz(input int n);
		for (i = 0; i < n; i++) begin
			if (zeroize_done === 1'b1 && kem_grant === 1'b0) break;
			@(posedge clk);
		end
		if (i == n) begin
			err_count++;
			$display("ERROR wait_idle expected 1 seen 0");
			end_of_test();
		end
	endtask : wz
	// results are matched against the oldest note
	always @(posedge clk) begin
		if (rd_p === 1'b1) begin
			rn = rq.size() ? rq.pop_front() : 32'hx;
			chk("reg_rdata", rn, reg_rdata);
		end
		rd_p = reg_rd;
		if (host_ack !== 1'b0 || host_deny !== 1'b0) begin
			if (hq.size() == 0) begin
				chk("host_answer", 32'h0, 32'h1);
			end else begin
				hn = hq.pop_front();
				if (hn[33]) chk("host_rdata", hn[31:0], host_rdata);
				chk("host_ack", {31'h0, hn[32]}, {31'h0, host_ack});
				chk("host_deny", {31'h0, ~hn[32]}, {31'h0, host_deny});
			end
		end
	end
	initial begin
		seed = 32'hd2ca;
		{clk_en, nrst, reg_wr, reg_rd, host_req, host_we, rd_p} = 7'h40;
		{zeroize_pin, intrusion_pin, jtag_active, scan_active} = 4'h0;
		{reg_addr, reg_wdata, host_addr, host_wdata, lat} = '0;
		reg_supv = 1'b0;
		chip_key = {$random(seed), $random(seed), $random(seed), $random(seed)};
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		hx(1'b0, 9'h000, 32'h0, 34'h0);
		rd(srza_pkg::OFF_LEN, 32'h0);
		reg_supv <= 1'b1;
		wz(600);
		hx(1'b1, 9'h001, 32'h1, 34'h0);
		wr(srza_pkg::OFF_TLOAD, 32'h0000_0fa0);
		wr(srza_pkg::OFF_SSC, 32'h1);
		chk("secure_state", 32'h1, {31'h0, secure_state});
		for (j = 0; j < 4; j++) begin
			aa[j] = {j[1:0], 1'b0, 6'($random(seed))};
			dd[j] = $random(seed);
			hx(1'b1, aa[j], dd[j], 34'h1_0000_0000);
		end
		hx(1'b1, srza_pkg::SRAM_LAST, 32'h5, 34'h1_0000_0000);
		for (j = 0; j < 4; j++) hx(1'b0, aa[j], 32'h0, {2'h3, dd[j]});
		hx(1'b0, srza_pkg::SRAM_LAST, 32'h0, 34'h3_0000_0005);
		for (j = 0; j < 2; j++) begin
			lat <= j ? 8'h28 : 8'h02;
			wr(srza_pkg::OFF_RED, {23'h0, aa[j]});
			wr(srza_pkg::OFF_CTRL, 32'h1);
			if (j) hx(1'b0, aa[j], 32'h0, 34'h0);
			wz(100);
			hx(1'b0, aa[j], 32'h0, {2'h3, 24'hc0de00, lat});
			chk("kem_rdata", dd[j], kem_rdata);
		end
		chk("irq", 32'h0, {31'h0, irq});
		wr(srza_pkg::OFF_IMASK, 32'h2);
		chk("irq", 32'h1, {31'h0, irq});
		rd(srza_pkg::OFF_ISTS, 32'h13);
		chk("irq", 32'h0, {31'h0, irq});
		wr(srza_pkg::OFF_BLACK, {23'h0, aa[3]});
		wr(srza_pkg::OFF_IV1, dd[0]);
		wr(srza_pkg::OFF_CTRL, 32'h2);
		chk("black", {23'h0, aa[3]}, {23'h0, kem_black_start});
		chk("iv1", dd[0], kem_iv1);
		chk("decrypt", 32'h1, {31'h0, kem_decrypt});
		wr(srza_pkg::OFF_ICTL, 32'h1);
		hx(1'b0, aa[2], 32'h0, 34'h0);
		wz(600);
		hx(1'b0, aa[2], 32'h0, 34'h3_0000_0000);
		rd(srza_pkg::OFF_RED, 32'h0);
		chk("black", 32'h0, {23'h0, kem_black_start});
		chk("iv1", 32'h0, kem_iv1);
		chk("decrypt", 32'h0, {31'h0, kem_decrypt});
		chk("kem_rdata", 32'h0, kem_rdata);
		wr(srza_pkg::OFF_TLOAD, 32'h10);
		repeat (24) @(posedge clk);
		chk("sm_err", 32'h1, {31'h0, security_monitor_err});
		rd(srza_pkg::OFF_ERR, 32'h3);
		jtag_active <= 1'b1;
		scan_active <= 1'b1;
		repeat (6) @(posedge clk);
		chk("dbg_alert", 32'h1, {31'h0, ssc_debug_alert});
		rd(srza_pkg::OFF_DBG, 32'h3);
		chk("secure_state", 32'h0, {31'h0, secure_state});
		intrusion_pin <= 1'b1;
		repeat (6) @(posedge clk);
		chk("zeroize_done", 32'h0, {31'h0, zeroize_done});
		wz(600);
		intrusion_pin <= 1'b0;
		zeroize_pin <= 1'b1;
		repeat (6) @(posedge clk);
		chk("zeroize_done", 32'h0, {31'h0, zeroize_done});
		wz(600);
		chk("pending", 32'h0, 32'(hq.size() + rq.size()));
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule : srza_tb_top
